// ---- inc/sref_params.svh ----
// Register offsets, field positions and reset values of the serial receive-error flag block.
`ifndef SREF_PARAMS_SVH
`define SREF_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SREF_ADDR_CTRL     8'h00
`define SREF_ADDR_STATUS   8'h04
`define SREF_ADDR_RXDATA   8'h08
`define SREF_ADDR_IRQ_STAT 8'h0C
`define SREF_ADDR_IRQ_CLR  8'h10
`define SREF_ADDR_IRQ_EN   8'h14

// ----------------------------------------
// Control register field positions
// ----------------------------------------
`define SREF_CTRL_RX_ON    0
`define SREF_CTRL_TX_ON    1
`define SREF_CTRL_SYNC     2
`define SREF_CTRL_PAR_EN   3
`define SREF_CTRL_PAR_ODD  4
`define SREF_CTRL_TWO_STOP 5

// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define SREF_STAT_FULL     6
`define SREF_STAT_FRAME    4
`define SREF_STAT_PARITY   3
`define SREF_STAT_TXDONE   2

// ----------------------------------------
// Interrupt status field positions
// ----------------------------------------
`define SREF_IRQ_FULL      0
`define SREF_IRQ_FRAME     1
`define SREF_IRQ_PARITY    2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SREF_RST_CTRL      6'h00
`define SREF_RST_TXDONE    1'b1
`define SREF_RST_FAULT     1'b0
`define SREF_RST_IRQ       3'h0

`endif

// ---- inc/sref_pkg.sv ----
// Types shared by the serial receive-error flag block.
package sref_pkg;

  // Control register contents.
  typedef struct packed {
    logic two_stop;
    logic parity_odd;
    logic parity_en;
    logic sync_mode;
    logic transmitter_on_bit;
    logic receiver_on_bit;
  } sref_ctrl_type;

  // Flags of the serial status register.
  typedef struct packed {
    logic rx_buffer_full_flag;
    logic framing_fault_flag;
    logic parity_fault_flag;
    logic tx_done_flag;
  } sref_flags_type;

endpackage

// ---- inc/sref_chk_if.sv ----
// Interface that carries one received character to the checker and its verdict back.
`timescale 1ns/1ps
interface sref_chk_if;
  logic       char_valid;
  logic [7:0] char_data;
  logic       stop_first;
  logic       stop_second;
  logic       parity_bit;
  logic       async_mode;
  logic       parity_en;
  logic       parity_odd;
  logic       done;
  logic [7:0] data_q;
  logic       framing_bad;
  logic       parity_bad;

  // The top feeds a character and reads the verdict.
  modport feed (output char_valid, char_data, stop_first, stop_second, parity_bit,
                output async_mode, parity_en, parity_odd,
                input done, data_q, framing_bad, parity_bad);
  // The checker judges a character.
  modport judge (input char_valid, char_data, stop_first, stop_second, parity_bit,
                 input async_mode, parity_en, parity_odd,
                 output done, data_q, framing_bad, parity_bad);
endinterface

// ---- design/sref_frame_check.sv ----
// Checker that judges the stop and parity bits of one received character.
`timescale 1ns/1ps
`include "sref_params.svh"
module sref_frame_check (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Character in, verdict out.
  sref_chk_if.judge chk
);
  import sref_pkg::*;

  logic       done_q,   done_d;
  logic [7:0] data_q,   data_d;
  logic       frame_q,  frame_d;
  logic       parity_q, parity_d;

  // Returns one when the parity bit does not match the chosen sense.
  function automatic logic parity_mismatch(input logic [7:0] d, input logic p, input logic odd);
    parity_mismatch = ((^d) ^ p) != odd;
  endfunction

  // Only the first stop bit decides a framing fault; the second one is never looked at.
  always_comb begin
    done_d   = chk.char_valid;
    data_d   = chk.char_valid ? chk.char_data : data_q;
    frame_d  = chk.char_valid & chk.async_mode & ~chk.stop_first; // RL1 RL2
    parity_d = chk.char_valid & chk.async_mode & chk.parity_en &
               parity_mismatch(chk.char_data, chk.parity_bit, chk.parity_odd); // RL8
  end

  // Verdict registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q   <= 1'b0;
      data_q   <= 8'h00;
      frame_q  <= 1'b0;
      parity_q <= 1'b0;
    end else begin
      done_q   <= done_d;
      data_q   <= data_d;
      frame_q  <= frame_d;
      parity_q <= parity_d;
    end
  end

  assign chk.done        = done_q;
  assign chk.data_q      = data_q;
  assign chk.framing_bad = frame_q;
  assign chk.parity_bad  = parity_q;
endmodule

// ---- design/sref_top.sv ----
// Receive-error and transmit-done status logic of the serial port, with its register slave.
//
// Notes on behaviour
// RL1 - Stop bit sampled 0 sets framing fault.
// RL2 - Two stop bits: check only the first.
// RL3 - Framing fault: load character, no full flag.
// RL4 - Framing fault pending stops further reception.
// RL5 - Synchronous mode: error also stops transmission.
// RL6 - Framing fault clears by zero after one.
// RL7 - Receiver off keeps framing fault.
// RL8 - Parity mismatch sets parity fault; the code checks parity in asynchronous mode only.
// RL9 - Parity fault: load character, no full flag.
// RL10 - Parity fault pending stops further reception.
// RL11 - Parity fault clears by zero after one.
// RL12 - Receiver off keeps parity fault.
// RL13 - Transmitter off holds transmit done set.
// RL14 - Transmit done read-only, resets to one.
// RL15 - Writing one to fault flags does nothing.
// RL16 - Normal end sets receive full flag.
// RL17 - Clear uses flag value seen at read.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "sref_params.svh"
module sref_top (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Register port.
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [7:0]                  rdata,
  // Character from the receive shift register.
  input  wire logic                   rx_char_valid,
  input  wire logic [7:0]             rx_char_data,
  input  wire logic                   rx_stop_first,
  input  wire logic                   rx_stop_second,
  input  wire logic                   rx_parity_bit,
  // Transmitter handshake.
  input  wire logic                   tx_char_start,
  // Status towards the shifters.
  output logic                        rx_hold,
  output logic                        tx_hold,
  output sref_pkg::sref_flags_type    flags,
  output logic [7:0]                  rx_holding_reg,
  // Interrupt.
  output logic                        irq
);
  import sref_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  sref_ctrl_type  ctrl_q,   ctrl_d;
  sref_flags_type flags_q,  flags_d;
  sref_flags_type seen_q,   seen_d;
  logic [7:0]     hold_q,   hold_d;
  logic [2:0]     istat_q,  istat_d;
  logic [2:0]     ien_q,    ien_d;
  logic [7:0]     rdata_q,  rdata_d;

  logic           accept;
  logic           fault_any;
  logic           good_char;
  logic           status_wr;
  logic           status_rd;
  logic           tx_go;

  sref_chk_if chk ();

  // ----------------------------------------
  // Character checker
  // ----------------------------------------
  sref_frame_check u_check (
    .clk   (clk),
    .reset (reset),
    .chk   (chk)
  );

  // A character is taken only while the receiver is on and no fault is pending.
  assign accept = rx_char_valid & ctrl_q.receiver_on_bit & ~rx_hold; // RL4 RL10
  assign chk.char_valid  = accept;
  assign chk.char_data   = rx_char_data;
  assign chk.stop_first  = rx_stop_first;
  assign chk.stop_second = rx_stop_second;
  assign chk.parity_bit  = rx_parity_bit;
  assign chk.async_mode  = ~ctrl_q.sync_mode;
  assign chk.parity_en   = ctrl_q.parity_en;
  assign chk.parity_odd  = ctrl_q.parity_odd;

  // Verdict decoding.
  assign fault_any = chk.framing_bad | chk.parity_bad;
  assign good_char = chk.done & ~fault_any;

  // Bus decode.
  assign status_wr = wr & (addr == `SREF_ADDR_STATUS);
  assign status_rd = rd & (addr == `SREF_ADDR_STATUS);

  // Receive errors hold both directions in synchronous mode.
  assign rx_hold = flags_q.framing_fault_flag | flags_q.parity_fault_flag; // RL4 RL10
  assign tx_hold = ctrl_q.sync_mode & rx_hold; // RL5
  assign tx_go   = tx_char_start & ctrl_q.transmitter_on_bit & ~tx_hold; // RL5

  // Clear-after-read: returns the flag after a write, with a new set winning.
  function automatic logic flag_next(input logic cur, input logic set, input logic seen,
                                     input logic wr_bit, input logic do_wr);
    logic clr;
    clr       = do_wr & ~wr_bit & seen; // RL6 RL11 RL15 RL17
    flag_next = set | (cur & ~clr);
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    ctrl_d  = ctrl_q;
    seen_d  = seen_q;
    hold_d  = hold_q;
    ien_d   = ien_q;
    rdata_d = 8'h00;
    // Control register write.
    if (wr && addr == `SREF_ADDR_CTRL) begin
      ctrl_d = sref_ctrl_type'(wdata[5:0]);
    end
    if (wr && addr == `SREF_ADDR_IRQ_EN) begin
      ien_d = wdata[2:0];
    end
    // Snapshot of the flags at each status read.
    if (status_rd) begin
      seen_d = flags_q; // RL17
    end
    // Holding register takes every judged character, faulty or not.
    if (chk.done) begin
      hold_d = chk.data_q; // RL3 RL9
    end
    // Receiver off leaves the flags alone; they change only by events and writes.
    flags_d.framing_fault_flag = flag_next(flags_q.framing_fault_flag, chk.framing_bad, // RL1 RL7
                                           seen_q.framing_fault_flag,
                                           wdata[`SREF_STAT_FRAME], status_wr);
    flags_d.parity_fault_flag  = flag_next(flags_q.parity_fault_flag, chk.parity_bad, // RL8 RL12
                                           seen_q.parity_fault_flag,
                                           wdata[`SREF_STAT_PARITY], status_wr);
    flags_d.rx_buffer_full_flag = flag_next(flags_q.rx_buffer_full_flag, good_char, // RL16 RL3 RL9
                                            seen_q.rx_buffer_full_flag,
                                            wdata[`SREF_STAT_FULL], status_wr);
    // Transmit done is read-only: set while transmitter off, cleared by a start.
    flags_d.tx_done_flag = ~ctrl_q.transmitter_on_bit | (flags_q.tx_done_flag & ~tx_go); // RL13 RL14
    // Interrupt status: sticky, write one to clear, set wins.
    istat_d = istat_q;
    if (wr && addr == `SREF_ADDR_IRQ_CLR) begin
      istat_d = istat_q & ~wdata[2:0];
    end
    istat_d[`SREF_IRQ_FULL]   = istat_d[`SREF_IRQ_FULL] | good_char;
    istat_d[`SREF_IRQ_FRAME]  = istat_d[`SREF_IRQ_FRAME] | chk.framing_bad;
    istat_d[`SREF_IRQ_PARITY] = istat_d[`SREF_IRQ_PARITY] | chk.parity_bad;
    // Read data for the next cycle.
    if (rd) begin
      case (addr)
        `SREF_ADDR_CTRL: begin
          rdata_d = {2'b00, ctrl_q};
        end
        `SREF_ADDR_STATUS: begin
          rdata_d = {1'b0, flags_q.rx_buffer_full_flag, 1'b0, flags_q.framing_fault_flag,
                     flags_q.parity_fault_flag, flags_q.tx_done_flag, 2'b00};
        end
        `SREF_ADDR_RXDATA: begin
          rdata_d = hold_q;
        end
        `SREF_ADDR_IRQ_STAT: begin
          rdata_d = {5'h00, istat_q};
        end
        `SREF_ADDR_IRQ_EN: begin
          rdata_d = {5'h00, ien_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q  <= sref_ctrl_type'(`SREF_RST_CTRL);
      flags_q <= {`SREF_RST_FAULT, `SREF_RST_FAULT, `SREF_RST_FAULT, `SREF_RST_TXDONE}; // RL14
      seen_q  <= 4'h0;
      hold_q  <= 8'h00;
      istat_q <= `SREF_RST_IRQ;
      ien_q   <= `SREF_RST_IRQ;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q  <= ctrl_d;
      flags_q <= flags_d;
      seen_q  <= seen_d;
      hold_q  <= hold_d;
      istat_q <= istat_d;
      ien_q   <= ien_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs.
  assign rdata          = rdata_q;
  assign flags          = flags_q;
  assign rx_holding_reg = hold_q;
  assign irq            = |(istat_q & ien_q);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_stop_zero_frame: assert property ( // RL1
    accept && !ctrl_q.sync_mode && !rx_stop_first |-> ##2 flags_q.framing_fault_flag)
    else $error("framing fault not set on zero stop bit");

  chk_second_stop_free: assert property ( // RL2
    accept && !ctrl_q.sync_mode && rx_stop_first && !rx_stop_second && !ctrl_q.parity_en
    |-> ##2 !flags_q.framing_fault_flag)
    else $error("second stop bit raised a framing fault");

  chk_fault_loads_data: assert property ( // RL3
    chk.done && fault_any |=> hold_q == $past(chk.data_q) && !$rose(flags_q.rx_buffer_full_flag))
    else $error("faulty character handling wrong");

  chk_held_no_receive: assert property ( // RL4
    rx_hold && rx_char_valid |=> !chk.done)
    else $error("reception continued during a fault");

  chk_sync_tx_hold: assert property ( // RL5
    ctrl_q.sync_mode && rx_hold && flags_q.tx_done_flag && tx_char_start |=> flags_q.tx_done_flag)
    else $error("transmission started during a fault");

  chk_clear_needs_read: assert property ( // RL6
    status_wr && !wdata[`SREF_STAT_FRAME] && !seen_q.framing_fault_flag && flags_q.framing_fault_flag
    |=> flags_q.framing_fault_flag)
    else $error("framing fault cleared without read");

  chk_rx_off_keeps: assert property ( // RL7
    wr && addr == `SREF_ADDR_CTRL && !wdata[`SREF_CTRL_RX_ON] && ctrl_q.receiver_on_bit && !chk.framing_bad
    |=> flags_q.framing_fault_flag == $past(flags_q.framing_fault_flag))
    else $error("receiver off changed the framing fault");

  chk_parity_sets: assert property ( // RL8
    chk.done && chk.parity_bad |=> flags_q.parity_fault_flag [*1] ##0 rx_hold)
    else $error("parity fault not set");

  chk_tx_off_done: assert property ( // RL13
    !ctrl_q.transmitter_on_bit |=> flags_q.tx_done_flag)
    else $error("transmit done low with transmitter off");

  chk_reset_values: assert property (@(posedge clk) disable iff (1'b0) // RL14
    reset |=> flags_q.tx_done_flag && !flags_q.framing_fault_flag && !flags_q.parity_fault_flag)
    else $error("flag reset values wrong");

  chk_write_one_noop: assert property ( // RL15
    status_wr && wdata[`SREF_STAT_PARITY] && flags_q.parity_fault_flag |=> flags_q.parity_fault_flag)
    else $error("writing one cleared a fault");

  chk_good_sets_full: assert property ( // RL16
    accept && !ctrl_q.sync_mode && rx_stop_first && !ctrl_q.parity_en |-> ##2 flags_q.rx_buffer_full_flag)
    else $error("full flag not set on good character");

  chk_set_beats_clear: assert property ( // RL17
    status_wr && chk.framing_bad |=> flags_q.framing_fault_flag)
    else $error("new framing fault lost to clear");

  // Load, hold, clear and write rules that apply to one flag at a time.
  chk_frame_blocks_rx: assert property ( // RL4
    flags_q.framing_fault_flag |-> !accept)
    else $error("character accepted during a framing fault");

  chk_parity_loads_data: assert property ( // RL9
    chk.done && chk.parity_bad |=> hold_q == $past(chk.data_q) && !$rose(flags_q.rx_buffer_full_flag))
    else $error("parity faulty character handling wrong");

  chk_parity_blocks_rx: assert property ( // RL10
    flags_q.parity_fault_flag |-> !accept)
    else $error("character accepted during a parity fault");

  chk_parity_clears: assert property ( // RL11
    status_wr && !wdata[`SREF_STAT_PARITY] && seen_q.parity_fault_flag && !chk.parity_bad
    |=> !flags_q.parity_fault_flag)
    else $error("parity fault not cleared after read");

  chk_rx_off_parity: assert property ( // RL12
    wr && addr == `SREF_ADDR_CTRL && !wdata[`SREF_CTRL_RX_ON] && ctrl_q.receiver_on_bit && !chk.parity_bad
    |=> flags_q.parity_fault_flag == $past(flags_q.parity_fault_flag))
    else $error("receiver off changed the parity fault");

  chk_frame_write_one: assert property ( // RL15
    status_wr && wdata[`SREF_STAT_FRAME] && flags_q.framing_fault_flag |=> flags_q.framing_fault_flag)
    else $error("writing one cleared a framing fault");

  cov_frame_fault: cover property (chk.done && chk.framing_bad);
  cov_parity_fault: cover property (chk.done && chk.parity_bad);
  cov_read_clear: cover property (status_rd ##2 status_wr && rx_hold ##1 !rx_hold);
  cov_good_char: cover property (good_char ##1 irq);
  cov_clear_race: cover property (status_wr && chk.framing_bad);
endmodule

// ---- sim/sref_char_src.sv ----
// Behavioural model of the remote transmitter that hands received characters to the block.
`timescale 1ns/1ps
module sref_char_src (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset,
  // Request from the bench.
  input  wire logic       send,
  input  wire logic [7:0] char_in,
  input  wire logic       stop1_in,
  input  wire logic       stop2_in,
  input  wire logic       par_in,
  // Character towards the block.
  output logic            char_valid,
  output logic [7:0]      char_data,
  output logic            stop_first,
  output logic            stop_second,
  output logic            parity_bit
);
  // ----------------------------------------
  // Character presentation
  // ----------------------------------------
  // A character stands for one cycle; between characters the lines toggle so stale values never look valid.
  always_ff @(posedge clk) begin
    if (reset) begin
      char_valid  <= 1'b0;
      char_data   <= 8'h00;
      stop_first  <= 1'b0;
      stop_second <= 1'b0;
      parity_bit  <= 1'b0;
    end else if (send) begin
      char_valid  <= 1'b1;
      char_data   <= char_in;
      stop_first  <= stop1_in;
      stop_second <= stop2_in;
      parity_bit  <= par_in;
    end else begin
      char_valid  <= 1'b0;
      char_data   <= ~char_data;
      stop_first  <= ~stop_first;
      stop_second <= ~stop_second;
      parity_bit  <= ~parity_bit;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Self-checking testbench for the serial receive-error flag block.
`timescale 1ns/1ps
`include "sref_params.svh"
module testbench;
  import sref_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic           clk, reset, wr, rd, tx_char_start, send, c_s1, c_s2, c_par;
  logic [7:0]     addr, wdata, rdata, c_data, rx_char_data, rx_holding_reg, d;
  logic           rx_char_valid, rx_stop_first, rx_stop_second, rx_parity_bit;
  logic           rx_hold, tx_hold, irq;
  sref_flags_type flags;
  int             err_count, check_count;

  // Design and far-side model.
  sref_top sref_top_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_stop_first(rx_stop_first), .rx_stop_second(rx_stop_second), .rx_parity_bit(rx_parity_bit),
    .tx_char_start(tx_char_start), .rx_hold(rx_hold), .tx_hold(tx_hold), .flags(flags),
    .rx_holding_reg(rx_holding_reg), .irq(irq));
  sref_char_src sref_char_src_i (.clk(clk), .reset(reset), .send(send), .char_in(c_data),
    .stop1_in(c_s1), .stop2_in(c_s2), .par_in(c_par), .char_valid(rx_char_valid),
    .char_data(rx_char_data), .stop_first(rx_stop_first), .stop_second(rx_stop_second),
    .parity_bit(rx_parity_bit));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Has the far side send one character, then lets the verdict land.
  task automatic send_char(input logic [7:0] v, input logic s1, input logic s2, input logic p);
    @(posedge clk);
    c_data <= v;
    c_s1   <= s1;
    c_s2   <= s2;
    c_par  <= p;
    send   <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Reads the status and writes zero to clear every fault and full flag seen set.
  task automatic clear_status();
    reg_rd(`SREF_ADDR_STATUS, d);
    reg_wr(`SREF_ADDR_STATUS, 8'h00);
  endtask

  // Flags as {full, framing, parity, done}.
  function automatic logic [7:0] fl();
    return {4'h0, flags};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, read timing and an unmapped read.
  task automatic t_reset();
    check("flags", fl(), 8'h01);
    reg_rd(`SREF_ADDR_STATUS, d);
    check("status", d, 8'h04);
    @(posedge clk);
    #1;
    check("rdata idle", rdata, 8'h00);
    reg_rd(8'h20, d);
    check("unmapped", d, 8'h00);
  endtask

  // Good character with the second stop bit low.
  task automatic t_good();
    reg_wr(`SREF_ADDR_CTRL, 8'h21);
    send_char(8'h3C, 1'b1, 1'b0, 1'b0);
    check("flags", fl(), 8'h09);
    check("holding", rx_holding_reg, 8'h3C);
    clear_status();
    check("flags", fl(), 8'h01);
  endtask

  // Framing fault: hold, drop, clearing discipline and receiver off.
  task automatic t_frame();
    reg_wr(`SREF_ADDR_CTRL, 8'h01);
    reg_rd(`SREF_ADDR_STATUS, d);
    send_char(8'hA5, 1'b0, 1'b1, 1'b0);
    check("flags", fl(), 8'h05);
    check("holding", rx_holding_reg, 8'hA5);
    check("rx_hold", {7'h0, rx_hold}, 8'h01);
    send_char(8'h5A, 1'b1, 1'b1, 1'b0);
    check("holding", rx_holding_reg, 8'hA5);
    reg_wr(`SREF_ADDR_STATUS, 8'h00);
    check("flags", fl(), 8'h05);
    reg_rd(`SREF_ADDR_STATUS, d);
    check("status", d, 8'h14);
    reg_wr(`SREF_ADDR_STATUS, 8'h10);
    check("flags", fl(), 8'h05);
    reg_wr(`SREF_ADDR_CTRL, 8'h00);
    check("flags", fl(), 8'h05);
    reg_wr(`SREF_ADDR_STATUS, 8'h00);
    check("flags", fl(), 8'h01);
    reg_wr(`SREF_ADDR_CTRL, 8'h01);
    send_char(8'h5A, 1'b1, 1'b0, 1'b0);
    check("holding", rx_holding_reg, 8'h5A);
    clear_status();
  endtask

  // Parity fault in even and odd parity.
  task automatic t_parity();
    reg_wr(`SREF_ADDR_CTRL, 8'h09);
    send_char(8'h01, 1'b1, 1'b1, 1'b0);
    check("flags", fl(), 8'h03);
    check("holding", rx_holding_reg, 8'h01);
    send_char(8'h77, 1'b1, 1'b1, 1'b1);
    check("holding", rx_holding_reg, 8'h01);
    reg_wr(`SREF_ADDR_CTRL, 8'h08);
    check("flags", fl(), 8'h03);
    reg_wr(`SREF_ADDR_STATUS, 8'h08);
    check("flags", fl(), 8'h03);
    clear_status();
    check("flags", fl(), 8'h01);
    reg_wr(`SREF_ADDR_CTRL, 8'h19);
    send_char(8'h01, 1'b1, 1'b1, 1'b0);
    check("flags", fl(), 8'h09);
    send_char(8'h01, 1'b1, 1'b1, 1'b1);
    check("flags", fl(), 8'h0B);
    clear_status();
  endtask

  // One-cycle transmitter start pulse.
  task automatic pulse_tx();
    @(posedge clk);
    tx_char_start <= 1'b1;
    @(posedge clk);
    tx_char_start <= 1'b0;
    #1;
  endtask

  // Synchronous-mode transmit hold and the transmit done flag.
  task automatic t_tx();
    reg_wr(`SREF_ADDR_CTRL, 8'h03);
    send_char(8'h11, 1'b0, 1'b0, 1'b0);
    check("tx_hold", {7'h0, tx_hold}, 8'h00);
    reg_wr(`SREF_ADDR_CTRL, 8'h07);
    check("tx_hold", {7'h0, tx_hold}, 8'h01);
    pulse_tx();
    check("flags", fl(), 8'h05);
    clear_status();
    check("tx_hold", {7'h0, tx_hold}, 8'h00);
    pulse_tx();
    check("flags", fl(), 8'h00);
    reg_wr(`SREF_ADDR_STATUS, 8'h04);
    check("flags", fl(), 8'h00);
    reg_wr(`SREF_ADDR_CTRL, 8'h00);
    @(posedge clk);
    #1;
    check("flags", fl(), 8'h01);
  endtask

  // A status clear that lands on the edge of a new framing fault must not lose it.
  task automatic t_race();
    @(posedge clk);
    c_data <= 8'h44;
    c_s1   <= 1'b0;
    send   <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    addr  <= `SREF_ADDR_STATUS;
    wdata <= 8'h00;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
    check("flags", fl(), 8'h05);
    check("irq", {7'h0, irq}, 8'h01);
    clear_status();
    check("flags", fl(), 8'h01);
  endtask

  // Interrupt raise, mask and clear on a framing fault.
  task automatic t_irq();
    reg_wr(`SREF_ADDR_IRQ_CLR, 8'h07);
    reg_wr(`SREF_ADDR_IRQ_EN, 8'h02);
    reg_wr(`SREF_ADDR_CTRL, 8'h01);
    send_char(8'h22, 1'b0, 1'b1, 1'b0);
    check("irq", {7'h0, irq}, 8'h01);
    reg_wr(`SREF_ADDR_IRQ_STAT, 8'h00);
    reg_rd(`SREF_ADDR_IRQ_STAT, d);
    check("irq stat", d, 8'h02);
    reg_wr(`SREF_ADDR_IRQ_EN, 8'h00);
    check("irq", {7'h0, irq}, 8'h00);
    reg_wr(`SREF_ADDR_IRQ_EN, 8'h02);
    reg_wr(`SREF_ADDR_IRQ_CLR, 8'h02);
    check("irq", {7'h0, irq}, 8'h00);
    clear_status();
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  // Drives every input at time zero, resets, then runs the scenarios.
  initial begin
    err_count = 0;
    check_count = 0;
    reset = 1'b1;
    {wr, rd, tx_char_start, send, c_s1, c_s2, c_par} = 7'h00;
    {addr, wdata, c_data} = 24'h0000_00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_good();
    t_frame();
    t_parity();
    t_tx();
    t_irq();
    t_race();
    stop_test();
  end

  // Cuts a hang short well past the expected run of about 160 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule
